// ---- plt_defines.vh ----
// plt_defines.vh: offsets, field positions, reset values and timing counts
// assumes inclusion by plt_lock_tuning_ctrl.v, its property checker and the bench
`ifndef PLT_DEFINES_VH
`define PLT_DEFINES_VH
// ==========================================
// register offsets
`define PLT_ADDR_MOD_CFG 5'h06
`define PLT_ADDR_LOCK_CFG 5'h07
`define PLT_ADDR_CP_CFG 5'h09
`define PLT_ADDR_PIN_CFG 5'h0f
`define PLT_ADDR_STATUS 5'h12
`define PLT_ADDR_OUT_DIV 5'h16
`define PLT_ADDR_IRQ_STAT 5'h1c
`define PLT_ADDR_IRQ_MASK 5'h1d
// ==========================================
// field positions
`define PLT_MOD_FRAC_EN 11
`define PLT_MOD_BYPASS 7
`define PLT_LCK_THR_HI 2
`define PLT_LCK_DIGITAL 6
`define PLT_LCK_DIV_HI 7
`define PLT_LCK_DIV_LO 5
`define PLT_LCK_SPD_HI 9
`define PLT_LCK_SPD_LO 8
`define PLT_LCK_EN 11
`define PLT_PIN_SEL_HI 4
`define PLT_PIN_LOCK_ONLY 6
`define PLT_PIN_SEL_LOCK 5'h01
`define PLT_CP_OFS_HI 22
`define PLT_CP_OFS_LO 14
`define PLT_STAT_LOCK 1
`define PLT_STAT_SLIP 2
`define PLT_IRQ_LOCKED 0
`define PLT_IRQ_UNLOCKED 1
`define PLT_IRQ_SLIP 2
// ==========================================
// reset values
`define PLT_RST_MOD_CFG 12'h800
`define PLT_RST_LOCK_CFG 12'h000
`define PLT_RST_CP_CFG 23'h000000
`define PLT_RST_PIN_CFG 7'h00
`define PLT_RST_OUT_DIV 6'h00
// ==========================================
// timing: window figures in tenths of ns, clock rate in MHz
`define PLT_CLK_MHZ 20
`define PLT_ANALOG_WIN_NS10 12'h064
`define PLT_OSC_BAND_LO_MHZ 2050
`define PLT_OSC_BAND_HI_MHZ 4100
`define PLT_OUT_DIV_MAX 6'h3e
`endif

// ---- plt_lock_tuning_ctrl.v ----
// plt_lock_tuning_ctrl.v: lock qualifier, shared pin mux, slip guard,
// output divider and integer mode control of the synthesizer loop.
// assumes divided edges and serial read signals are synchronous pulses
// or levels on core_clk_i; the serial port itself lives outside.
// How it works
// R1 - analog 10 ns window unless digital bit set
// R2 - digital window from speed and divide fields
// R3 - host picks nearest table window entry
// R4 - selector one routes lock flag to pin
// R5 - pin high when locked, low otherwise
// R6 - serial read borrows pin, then lock returns
// R7 - lock-only bit pins lock, kills readback
// R8 - slip guard boosts gain on large error
// R9 - oscillator stays in fundamental band
// R10 - output divider even ratios two to 62
// R11 - integer mode holds modulator out
// R12 - integer step equals comparator frequency
// R13 - host zeroes charge pump offset in integer
// R14 - in-window edge pairs count toward lock threshold
// R15 - missed window clears count, drops lock
// R16 - detector runs only when enabled; status readable
// R17 - disabled detector holds flag and count clear
`timescale 1ns/1ps
`include "plt_defines.vh"
module plt_lock_tuning_ctrl #(
  parameter ADDR_W = 5,
  parameter DATA_W = 24
) (
  input wire core_clk_i,
  input wire rst_i,
  input wire [ADDR_W-1:0] reg_addr_i,
  input wire [DATA_W-1:0] reg_wdata_i,
  input wire reg_wr_i,
  input wire reg_rd_i,
  output reg [DATA_W-1:0] reg_rdata_o,
  input wire ref_edge_i,
  input wire osc_edge_i,
  input wire ser_rd_active_i,
  input wire serial_read_out_i,
  output wire lock_readback_shared_pin_o,
  output wire lock_readback_shared_pin_oe_o,
  output wire readback_avail_o,
  output wire lock_flag_o,
  output wire slip_guard_o,
  output reg [5:0] out_div_ratio_o,
  output reg out_div_bypass_o,
  output reg int_mode_o,
  output reg modulator_en_o,
  output wire irq_o
);
  // ==========================================
  // window table, tenths of ns, entry {speed, divide}, entry 0 rightmost
  localparam [383:0] WIN_TAB_NS10 = {
    12'hd34, 12'h6b8, 12'h370, 12'h1d6, 12'h104, 12'h09a, 12'h066, 12'h04c,
    12'haa0, 12'h564, 12'h2d0, 12'h17c, 12'h0dc, 12'h085, 12'h05c, 12'h047,
    12'h9f6, 12'h514, 12'h2a8, 12'h168, 12'h0d2, 12'h080, 12'h059, 12'h046,
    12'h79e, 12'h3e8, 12'h212, 12'h122, 12'h0aa, 12'h06e, 12'h050, 12'h041};
  function [3:0] win_cycles;
    input digital;
    input [1:0] spd;
    input [2:0] dv;
    reg [11:0] t;
    integer c;
    begin
      t = 12'h000;
      if (!digital) begin
        t = `PLT_ANALOG_WIN_NS10; // R1
      end else begin
        t = WIN_TAB_NS10[{spd, dv} * 12 +: 12]; // R2
      end
      // longest time, so round down; never below one cycle
      c = (t * `PLT_CLK_MHZ) / 10000;
      if (c < 1) begin
        c = 1;
      end
      win_cycles = c[3:0];
    end
  endfunction
  // ==========================================
  // configuration registers
  reg [11:0] mod_cfg_ff;
  reg [11:0] lock_cfg_ff;
  reg [22:0] cp_cfg_ff;
  reg [6:0] pin_cfg_ff;
  reg [5:0] out_div_ff;
  reg [2:0] irq_stat_ff;
  reg [2:0] irq_mask_ff;
  wire wr_mod = reg_wr_i && (reg_addr_i == `PLT_ADDR_MOD_CFG);
  wire wr_lock = reg_wr_i && (reg_addr_i == `PLT_ADDR_LOCK_CFG);
  wire wr_cp = reg_wr_i && (reg_addr_i == `PLT_ADDR_CP_CFG);
  wire wr_pin = reg_wr_i && (reg_addr_i == `PLT_ADDR_PIN_CFG);
  wire wr_div = reg_wr_i && (reg_addr_i == `PLT_ADDR_OUT_DIV);
  wire wr_istat = reg_wr_i && (reg_addr_i == `PLT_ADDR_IRQ_STAT);
  wire wr_imask = reg_wr_i && (reg_addr_i == `PLT_ADDR_IRQ_MASK);
  always @(posedge core_clk_i) begin
    if (rst_i) begin
      mod_cfg_ff <= `PLT_RST_MOD_CFG;
      lock_cfg_ff <= `PLT_RST_LOCK_CFG;
      cp_cfg_ff <= `PLT_RST_CP_CFG;
      pin_cfg_ff <= `PLT_RST_PIN_CFG;
      out_div_ff <= `PLT_RST_OUT_DIV;
      irq_mask_ff <= 3'h0;
    end else begin
      if (wr_mod) begin
        mod_cfg_ff <= reg_wdata_i[11:0];
      end
      if (wr_lock) begin
        lock_cfg_ff <= reg_wdata_i[11:0];
      end
      // offset field kept only for readback; host clears it in integer mode
      if (wr_cp) begin
        cp_cfg_ff <= reg_wdata_i[22:0];
      end
      if (wr_pin) begin
        pin_cfg_ff <= reg_wdata_i[6:0];
      end
      if (wr_div) begin
        out_div_ff <= reg_wdata_i[5:0];
      end
      if (wr_imask) begin
        irq_mask_ff <= reg_wdata_i[2:0];
      end
    end
  end
  wire ld_en = lock_cfg_ff[`PLT_LCK_EN];
  wire ld_digital = lock_cfg_ff[`PLT_LCK_DIGITAL];
  wire [2:0] ld_thr = lock_cfg_ff[`PLT_LCK_THR_HI:0];
  wire [3:0] win_len = win_cycles(ld_digital, lock_cfg_ff[`PLT_LCK_SPD_HI:`PLT_LCK_SPD_LO],
                                  lock_cfg_ff[`PLT_LCK_DIV_HI:`PLT_LCK_DIV_LO]);
  // ==========================================
  // edge pair qualifier
  localparam ST_IDLE = 3'b001;
  localparam ST_WAIT_OSC = 3'b010;
  localparam ST_WAIT_REF = 3'b100;
  reg [2:0] state_ff;
  reg [2:0] nxt_state;
  reg [3:0] win_cnt_ff;
  reg [3:0] nxt_win_cnt;
  reg [2:0] lock_cnt_ff;
  reg [2:0] nxt_lock_cnt;
  reg lock_ff;
  reg nxt_lock;
  reg slip_ff;
  reg nxt_slip;
  reg hit, miss, slip_ev;
  always @* begin
    nxt_state = state_ff;
    nxt_win_cnt = win_cnt_ff;
    hit = 1'b0;
    miss = 1'b0;
    slip_ev = 1'b0;
    case (state_ff)
      ST_IDLE: begin
        if (ref_edge_i && osc_edge_i) begin
          hit = 1'b1;
        end else if (ref_edge_i) begin
          nxt_state = ST_WAIT_OSC;
          nxt_win_cnt = win_len;
        end else if (osc_edge_i) begin
          nxt_state = ST_WAIT_REF;
          nxt_win_cnt = win_len;
        end
      end
      ST_WAIT_OSC: begin
        if (osc_edge_i) begin
          hit = 1'b1;
          nxt_state = ST_IDLE;
        end else if (ref_edge_i) begin
          // same edge twice before its partner: large phase error
          miss = 1'b1;
          slip_ev = 1'b1;
          nxt_win_cnt = win_len;
        end else if (win_cnt_ff == 4'h1) begin
          miss = 1'b1;
          nxt_state = ST_IDLE;
        end else begin
          nxt_win_cnt = win_cnt_ff - 4'h1;
        end
      end
      ST_WAIT_REF: begin
        if (ref_edge_i) begin
          hit = 1'b1;
          nxt_state = ST_IDLE;
        end else if (osc_edge_i) begin
          miss = 1'b1;
          slip_ev = 1'b1;
          nxt_win_cnt = win_len;
        end else if (win_cnt_ff == 4'h1) begin
          miss = 1'b1;
          nxt_state = ST_IDLE;
        end else begin
          nxt_win_cnt = win_cnt_ff - 4'h1;
        end
      end
      default: begin
        nxt_state = ST_IDLE;
      end
    endcase
  end
  always @* begin
    nxt_lock_cnt = lock_cnt_ff;
    nxt_lock = lock_ff;
    nxt_slip = slip_ff;
    if (miss) begin
      nxt_lock_cnt = 3'h0; // R15
      nxt_lock = 1'b0; // R15
    end else if (hit) begin
      if (lock_cnt_ff != 3'h7) begin
        nxt_lock_cnt = lock_cnt_ff + 3'h1; // R14
      end
      nxt_lock = lock_ff || (nxt_lock_cnt >= ld_thr); // R14
    end
    // boost held from a slip until edges pair up again
    if (slip_ev) begin
      nxt_slip = 1'b1; // R8
    end else if (hit) begin
      nxt_slip = 1'b0; // R8
    end
  end
  always @(posedge core_clk_i) begin
    if (rst_i || !ld_en) begin
      state_ff <= ST_IDLE; // R16
      win_cnt_ff <= 4'h0;
      lock_cnt_ff <= 3'h0; // R17
      lock_ff <= 1'b0; // R17
    end else begin
      state_ff <= nxt_state;
      win_cnt_ff <= nxt_win_cnt;
      lock_cnt_ff <= nxt_lock_cnt;
      lock_ff <= nxt_lock;
    end
  end
  // slip kept over lock detect off; only the qualifier sets it, the qualifier or reset clears it
  always @(posedge core_clk_i) begin
    if (rst_i) begin
      slip_ff <= 1'b0;
    end else begin
      slip_ff <= nxt_slip; // R8
    end
  end
  assign lock_flag_o = lock_ff;
  assign slip_guard_o = slip_ff;
  // ==========================================
  // shared pin
  wire lock_only = pin_cfg_ff[`PLT_PIN_LOCK_ONLY];
  wire lock_sel = (pin_cfg_ff[`PLT_PIN_SEL_HI:0] == `PLT_PIN_SEL_LOCK);
  wire rd_on_pin = ser_rd_active_i && !lock_only; // R6
  reg pin_ff, pin_oe_ff;
  always @(posedge core_clk_i) begin
    if (rst_i) begin
      pin_ff <= 1'b0;
      pin_oe_ff <= 1'b0;
    end else if (lock_only) begin
      pin_ff <= lock_ff; // R7
      pin_oe_ff <= 1'b1;
    end else if (rd_on_pin) begin
      pin_ff <= serial_read_out_i; // R6
      pin_oe_ff <= 1'b1;
    end else if (lock_sel) begin
      pin_ff <= lock_ff; // R4 R5
      pin_oe_ff <= 1'b1;
    end else begin
      pin_ff <= 1'b0;
      pin_oe_ff <= 1'b0;
    end
  end
  assign lock_readback_shared_pin_o = pin_ff;
  assign lock_readback_shared_pin_oe_o = pin_oe_ff;
  assign readback_avail_o = !lock_only; // R7
  // ==========================================
  // output divider and modulator mode
  always @(posedge core_clk_i) begin
    if (rst_i) begin
      out_div_ratio_o <= 6'h01;
      out_div_bypass_o <= 1'b1;
      int_mode_o <= 1'b0;
      modulator_en_o <= 1'b0;
    end else begin
      // odd codes round down to even; 0 and 1 leave the fundamental
      if (out_div_ff < 6'h02) begin
        out_div_ratio_o <= 6'h01; // R9
        out_div_bypass_o <= 1'b1;
      end else begin
        out_div_ratio_o <= {out_div_ff[5:1], 1'b0}; // R10
        out_div_bypass_o <= 1'b0;
      end
      int_mode_o <= !mod_cfg_ff[`PLT_MOD_FRAC_EN] && mod_cfg_ff[`PLT_MOD_BYPASS]; // R11 R12
      modulator_en_o <= mod_cfg_ff[`PLT_MOD_FRAC_EN] && !mod_cfg_ff[`PLT_MOD_BYPASS]; // R11
    end
  end
  // ==========================================
  // interrupts: set beats write-one-to-clear
  wire [2:0] irq_set = {slip_ev && !slip_ff, lock_ff && !nxt_lock && ld_en, !lock_ff && nxt_lock && ld_en};
  wire [2:0] irq_clr = wr_istat ? reg_wdata_i[2:0] : 3'h0;
  always @(posedge core_clk_i) begin
    if (rst_i) begin
      irq_stat_ff <= 3'h0;
    end else begin
      irq_stat_ff <= (irq_stat_ff & ~irq_clr) | irq_set;
    end
  end
  assign irq_o = |(irq_stat_ff & irq_mask_ff);
  // ==========================================
  // read port
  always @(posedge core_clk_i) begin
    if (rst_i) begin
      reg_rdata_o <= {DATA_W{1'b0}};
    end else if (reg_rd_i) begin
      if (reg_addr_i == `PLT_ADDR_MOD_CFG) begin
        reg_rdata_o <= {12'h000, mod_cfg_ff};
      end else if (reg_addr_i == `PLT_ADDR_LOCK_CFG) begin
        reg_rdata_o <= {12'h000, lock_cfg_ff};
      end else if (reg_addr_i == `PLT_ADDR_CP_CFG) begin
        reg_rdata_o <= {1'b0, cp_cfg_ff};
      end else if (reg_addr_i == `PLT_ADDR_PIN_CFG) begin
        reg_rdata_o <= {17'h00000, pin_cfg_ff};
      end else if (reg_addr_i == `PLT_ADDR_STATUS) begin
        reg_rdata_o <= {21'h000000, slip_ff, lock_ff, 1'b0}; // R16
      end else if (reg_addr_i == `PLT_ADDR_OUT_DIV) begin
        reg_rdata_o <= {18'h00000, out_div_ff};
      end else if (reg_addr_i == `PLT_ADDR_IRQ_STAT) begin
        reg_rdata_o <= {21'h000000, irq_stat_ff};
      end else if (reg_addr_i == `PLT_ADDR_IRQ_MASK) begin
        reg_rdata_o <= {21'h000000, irq_mask_ff};
      end else begin
        reg_rdata_o <= {DATA_W{1'b0}};
      end
    end else begin
      reg_rdata_o <= {DATA_W{1'b0}};
    end
  end
endmodule // plt_lock_tuning_ctrl

// ---- plt_lock_tuning_ctrl_properties.sv ----
// port checker for the lock and tuning block
// assumes bind into plt_lock_tuning_ctrl; one clock, sync reset
`timescale 1ns/1ps
`include "plt_defines.vh"
module plt_lock_props #(
  parameter ADDR_W = 5,
  parameter DATA_W = 24
) (
  input wire core_clk_i,
  input wire rst_i,
  input wire [ADDR_W-1:0] reg_addr_i,
  input wire reg_rd_i,
  input wire [DATA_W-1:0] reg_rdata_o,
  input wire ref_edge_i,
  input wire osc_edge_i,
  input wire ser_rd_active_i,
  input wire serial_read_out_i,
  input wire lock_readback_shared_pin_o,
  input wire lock_readback_shared_pin_oe_o,
  input wire readback_avail_o,
  input wire lock_flag_o,
  input wire slip_guard_o,
  input wire [5:0] out_div_ratio_o,
  input wire out_div_bypass_o,
  input wire int_mode_o,
  input wire modulator_en_o
);
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (rst_i);
  // ==========================================
  // shared pin: mux is registered, so one cycle late
  sequence lo_two;
    !readback_avail_o [*2];
  endsequence
  sequence rd_borrow;
    readback_avail_o && ser_rd_active_i;
  endsequence
  pin_lock_only_a: assert property (lo_two |->
    lock_readback_shared_pin_o == $past(lock_flag_o) && lock_readback_shared_pin_oe_o) else $error("pin not lock");
  pin_readback_a: assert property (rd_borrow |=>
    lock_readback_shared_pin_o == $past(serial_read_out_i) && lock_readback_shared_pin_oe_o) else $error("pin not data");
  // ==========================================
  // lock and slip only rise on a divided edge; status read shows both
  lock_rise_a: assert property ($rose(lock_flag_o) |-> $past(ref_edge_i || osc_edge_i))
    else $error("lock rose without edge");
  slip_rise_a: assert property ($rose(slip_guard_o) |-> $past(ref_edge_i || osc_edge_i))
    else $error("slip rose without edge");
  status_read_a: assert property ($past(reg_rd_i && reg_addr_i == `PLT_ADDR_STATUS) |->
    reg_rdata_o[2:1] == {$past(slip_guard_o), $past(lock_flag_o)}) else $error("status read wrong");
  // ==========================================
  // tuning outputs
  int_mode_a: assert property (!(int_mode_o && modulator_en_o))
    else $error("integer and modulator both on");
  div_even_a: assert property (out_div_ratio_o == 6'h01 || (!out_div_ratio_o[0] && out_div_ratio_o != 6'h00))
    else $error("divider ratio odd");
  div_bypass_a: assert property (out_div_bypass_o == (out_div_ratio_o == 6'h01))
    else $error("bypass mismatch");
endmodule // plt_lock_props
bind plt_lock_tuning_ctrl plt_lock_props #(.ADDR_W(ADDR_W), .DATA_W(DATA_W)) plt_lock_props_i (
  .core_clk_i(core_clk_i), .rst_i(rst_i), .reg_addr_i(reg_addr_i), .reg_rd_i(reg_rd_i),
  .reg_rdata_o(reg_rdata_o), .ref_edge_i(ref_edge_i), .osc_edge_i(osc_edge_i),
  .ser_rd_active_i(ser_rd_active_i), .serial_read_out_i(serial_read_out_i),
  .lock_readback_shared_pin_o(lock_readback_shared_pin_o),
  .lock_readback_shared_pin_oe_o(lock_readback_shared_pin_oe_o), .readback_avail_o(readback_avail_o),
  .lock_flag_o(lock_flag_o), .slip_guard_o(slip_guard_o), .out_div_ratio_o(out_div_ratio_o),
  .out_div_bypass_o(out_div_bypass_o), .int_mode_o(int_mode_o), .modulator_en_o(modulator_en_o));

// ---- plt_host_model.sv ----
// serial host side: read activity and read data bits
// assumes go_i is a level from the bench on core_clk_i
`timescale 1ns/1ps
module plt_host_model (
  input wire core_clk_i,
  input wire rst_i,
  input wire go_i,
  output logic ser_rd_active_o,
  output logic serial_read_out_o
);
  logic [7:0] lfsr_ff;
  // ==========================================
  // data toggles while idle; in a read it follows lfsr_ff[0], so a bit can repeat
  always @(posedge core_clk_i) begin
    if (rst_i) begin
      lfsr_ff <= 8'h5a;
      ser_rd_active_o <= 1'b0;
      serial_read_out_o <= 1'b0;
    end else begin
      lfsr_ff <= {lfsr_ff[6:0], lfsr_ff[7] ^ lfsr_ff[5] ^ lfsr_ff[4] ^ lfsr_ff[3]};
      ser_rd_active_o <= go_i;
      serial_read_out_o <= ser_rd_active_o ? lfsr_ff[0] : ~serial_read_out_o;
    end
  end
endmodule // plt_host_model

// ---- tb.sv ----
// self-checking bench for plt_lock_tuning_ctrl
// assumes plt_host_model stands in for the serial host
`timescale 1ns/1ps
`include "plt_defines.vh"
`define CHK(nm, e, a) begin n_tests++; if ((a) !== (e)) begin err_count++; \
  $display("BAD %s exp %h got %h", nm, e, a); end end
module tb;
  logic core_clk_i = 0;
  logic rst_i = 1;
  logic [4:0] reg_addr_i = 5'h00;
  logic [23:0] reg_wdata_i = 24'h000000;
  logic reg_wr_i = 0;
  logic reg_rd_i = 0;
  logic ref_edge_i = 0;
  logic osc_edge_i = 0;
  logic host_go = 0;
  wire [23:0] rdata;
  wire [5:0] ratio;
  wire sra, serial_read_out, pin, pin_oe, avail, lock, slip, byp, imode, men, irq;
  logic [23:0] exp_q[$];
  logic [23:0] e;
  logic rd_d = 0;
  logic sd_d = 0;
  logic [31:0] rnd;
  logic [31:0] v;
  integer seed = 80598;
  integer err_count = 0;
  integer n_tests = 0;
  integer i;
  always #25 core_clk_i = ~core_clk_i;
  plt_lock_tuning_ctrl plt_lock_tuning_ctrl_i (.core_clk_i(core_clk_i), .rst_i(rst_i), .reg_addr_i(reg_addr_i),
    .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(rdata),
    .ref_edge_i(ref_edge_i), .osc_edge_i(osc_edge_i), .ser_rd_active_i(sra), .serial_read_out_i(serial_read_out),
    .lock_readback_shared_pin_o(pin), .lock_readback_shared_pin_oe_o(pin_oe), .readback_avail_o(avail),
    .lock_flag_o(lock), .slip_guard_o(slip), .out_div_ratio_o(ratio), .out_div_bypass_o(byp),
    .int_mode_o(imode), .modulator_en_o(men), .irq_o(irq));
  plt_host_model plt_host_model_i (.core_clk_i(core_clk_i), .rst_i(rst_i), .go_i(host_go),
    .ser_rd_active_o(sra), .serial_read_out_o(serial_read_out));
  // ==========================================
  // watcher: each read answer against the oldest note
  always @(posedge core_clk_i) begin
    rd_d <= reg_rd_i;
    sd_d <= serial_read_out;
    if (rd_d) begin
      e = exp_q.pop_front();
      `CHK("rdata", e, rdata)
    end
  end
  // ==========================================
  // drivers
  task automatic bus(input logic w, input logic r, input logic [4:0] a, input logic [23:0] d);
    reg_wr_i <= w;
    reg_rd_i <= r;
    reg_addr_i <= a;
    reg_wdata_i <= d;
    @(posedge core_clk_i);
  endtask
  task automatic wr(input logic [4:0] a, input logic [23:0] d);
    bus(1'b1, 1'b0, a, d);
  endtask
  task automatic rd(input logic [4:0] a, input logic [23:0] x);
    exp_q.push_back(x);
    rnd = $random(seed);
    bus(1'b0, 1'b1, a, rnd[23:0]);
  endtask
  task automatic idle(input integer n);
    repeat (n) begin
      rnd = $random(seed);
      bus(1'b0, 1'b0, rnd[4:0], rnd[23:0]);
    end
  endtask
  // gap 0 leaves the edges up for the next call, avoiding a double assign
  task automatic pulse(input logic r, input logic o, input integer gap);
    ref_edge_i <= r;
    osc_edge_i <= o;
    idle(1);
    if (gap > 0) begin
      ref_edge_i <= 1'b0;
      osc_edge_i <= 1'b0;
      idle(gap);
    end
  endtask
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  initial begin
    #(50 * 4000);
    err_count++;
    report_and_stop();
  end
  // ==========================================
  // scenarios
  initial begin
    repeat (10) @(posedge core_clk_i);
    rst_i <= 1'b0;
    idle(1);
    rd(`PLT_ADDR_MOD_CFG, 24'h000800);
    rd(`PLT_ADDR_LOCK_CFG, 24'h000000);
    rd(5'h03, 24'h000000);
    wr(`PLT_ADDR_STATUS, 24'hffffff);
    rd(`PLT_ADDR_STATUS, 24'h000000);
    idle(2);
    @(negedge core_clk_i);
    `CHK("ratio", 6'h01, ratio)
    `CHK("pin_oe", 1'b0, pin_oe)
    @(posedge core_clk_i);
    $display("test reset done");
    v = $random(seed);
    wr(`PLT_ADDR_CP_CFG, v[23:0]);
    rd(`PLT_ADDR_CP_CFG, {1'b0, v[22:0]});
    wr(`PLT_ADDR_CP_CFG, 24'h000000);
    wr(`PLT_ADDR_MOD_CFG, 24'h000080);
    idle(2);
    @(negedge core_clk_i);
    `CHK("int_mode", 1'b1, imode)
    `CHK("mod_en", 1'b0, men)
    @(posedge core_clk_i);
    wr(`PLT_ADDR_MOD_CFG, 24'h000800);
    idle(2);
    @(negedge core_clk_i);
    `CHK("mod_en", 1'b1, men)
    `CHK("int_mode", 1'b0, imode)
    @(posedge core_clk_i);
    $display("test integer done");
    for (i = 0; i < 8; i++) begin
      v = {$random(seed)} % 31;
      v = v * 2 + 2;
      if (i == 7) v = 32'h3f;
      wr(`PLT_ADDR_OUT_DIV, v[23:0]);
      idle(2);
      @(negedge core_clk_i);
      `CHK("ratio", v[5:0] & 6'h3e, ratio)
      `CHK("bypass", 1'b0, byp)
      @(posedge core_clk_i);
    end
    $display("test divider done");
    wr(`PLT_ADDR_PIN_CFG, 24'h000001);
    wr(`PLT_ADDR_IRQ_MASK, 24'h000001);
    wr(`PLT_ADDR_LOCK_CFG, 24'h000801);
    idle(1);
    pulse(1'b1, 1'b0, 0);
    pulse(1'b0, 1'b1, 3);
    rd(`PLT_ADDR_STATUS, 24'h000002);
    rd(`PLT_ADDR_IRQ_STAT, 24'h000001);
    idle(1);
    @(negedge core_clk_i);
    `CHK("irq", 1'b1, irq)
    `CHK("pin", 1'b1, pin)
    `CHK("pin_oe", 1'b1, pin_oe)
    @(posedge core_clk_i);
    host_go <= 1'b1;
    idle(2);
    repeat (4) begin
      @(negedge core_clk_i);
      `CHK("pin_rd", sd_d, pin)
      @(posedge core_clk_i);
    end
    wr(`PLT_ADDR_PIN_CFG, 24'h000041);
    idle(2);
    @(negedge core_clk_i);
    `CHK("avail", 1'b0, avail)
    `CHK("pin", 1'b1, pin)
    @(posedge core_clk_i);
    host_go <= 1'b0;
    wr(`PLT_ADDR_IRQ_STAT, 24'h000001);
    idle(1);
    @(negedge core_clk_i);
    `CHK("irq", 1'b0, irq)
    @(posedge core_clk_i);
    $display("test pin done");
    wr(`PLT_ADDR_LOCK_CFG, 24'h000000);
    idle(2);
    rd(`PLT_ADDR_STATUS, 24'h000000);
    wr(`PLT_ADDR_LOCK_CFG, 24'h000be0);
    idle(1);
    pulse(1'b1, 1'b0, 5);
    pulse(1'b0, 1'b1, 3);
    rd(`PLT_ADDR_STATUS, 24'h000002);
    pulse(1'b1, 1'b0, 8);
    rd(`PLT_ADDR_STATUS, 24'h000000);
    pulse(1'b1, 1'b0, 0);
    pulse(1'b1, 1'b0, 8);
    rd(`PLT_ADDR_STATUS, 24'h000004);
    rd(`PLT_ADDR_IRQ_STAT, 24'h000007);
    idle(3);
    @(negedge core_clk_i);
    `CHK("lock", 1'b0, lock)
    `CHK("slip", 1'b1, slip)
    `CHK("pin", 1'b0, pin)
    `CHK("irq", 1'b1, irq)
    @(posedge core_clk_i);
    $display("test window done");
    rst_i <= 1'b1;
    idle(2);
    rst_i <= 1'b0;
    idle(1);
    @(negedge core_clk_i);
    `CHK("slip", 1'b0, slip)
    `CHK("ratio", 6'h01, ratio)
    `CHK("pin_oe", 1'b0, pin_oe)
    `CHK("irq", 1'b0, irq)
    @(posedge core_clk_i);
    $display("test second reset done");
    report_and_stop();
  end
endmodule // tb
